// file: regctl_consts.svh
// Constants for the regulator output and manual step control block
`ifndef REGCTL_CONSTS_SVH
`define REGCTL_CONSTS_SVH
`define CLK_HZ          10000000
`define STEP_UNIT_MS    100
`define STEP_MIN_TENTHS 8'h01
`define STEP_MAX_TENTHS 8'h64
`define STEP_DEF_TENTHS 8'h32
`define OFFSET_MAX_PCT  8'h64
`define OFFSET_DEF_PCT  8'h32
`define OFS_SCALE       24'h00028F
`define REG_GOV_CTRL    4'h0
`define REG_AVR_CTRL    4'h1
`define REG_GOV_STEP    4'h2
`define REG_AVR_STEP    4'h3
`define REG_GOV_OFFSET  4'h4
`define REG_GOV_EXT_SP  4'h5
`define REG_AVR_EXT_SP  4'h6
`define REG_STATUS      4'h7
`define DRIVE_FLD_LSB   0
`define EXT_EN_BIT      2
`define EXT_MODE_LSB    3
`endif

// file: regctl_pkg.sv
// Types shared by the regulator output control block
package regctl_pkg;
    typedef enum logic [1:0]
    {
        DRIVE_RELAY  = 2'h0,
        DRIVE_ANALOG = 2'h1,
        DRIVE_ENGINE = 2'h2
    } drive_type_t;
    typedef enum logic [1:0]
    {
        EXT_FREQ  = 2'h0,
        EXT_POWER = 2'h1
    } gov_ext_mode_t;
    typedef enum logic [1:0]
    {
        EXT_VOLT  = 2'h0,
        EXT_VAR   = 2'h1,
        EXT_PF    = 2'h2
    } avr_ext_mode_t;
    typedef struct packed
    {
        logic        up;
        logic        down;
    } step_req_t;
    typedef struct packed
    {
        logic        inc_relay;
        logic        dec_relay;
        logic [15:0] analog;
        logic [15:0] engine;
    } reg_drive_t;
endpackage

// file: step_pulse.sv
// Timed manual step pulse generator for one regulator channel
`include "regctl_consts.svh"
module step_pulse
#(
    parameter int TICKS_PER_TENTH = `CLK_HZ / 1000 * `STEP_UNIT_MS
)
(
    input  wire logic       clk,        // System clock
    input  wire logic       sys_rst,    // Async reset, active high
    input  wire logic       allow,      // Manual or semi-auto mode
    input  wire logic       up_req,     // Increase request pulse
    input  wire logic       down_req,   // Decrease request pulse
    input  wire logic [7:0] dur_tenths, // Pulse length in 0.1 s
    output logic            up_on,      // Increase step running
    output logic            down_on     // Decrease step running
);
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_UP   = 2'b01,
        ST_DOWN = 2'b11
    } step_state_t;

    step_state_t  state_q;                  // Current step state
    step_state_t  state_d;                  // Next step state
    logic [23:0]  tick_q;                   // Cycles inside one tenth
    logic [7:0]   tenth_q;                  // Tenths left in the pulse
    logic         take_up;                  // Accepted increase
    logic         take_down;                // Accepted decrease
    logic         tenth_end;                // Last cycle of a tenth
    logic         done;                     // Pulse has expired
    logic         start;                    // A new pulse begins

    // Requests are ignored outside manual modes; both at once is no-op
    assign take_up   = allow && up_req && !down_req;
    assign take_down = allow && down_req && !up_req;
    assign start     = take_up || take_down;
    assign tenth_end = (tick_q == 24'(TICKS_PER_TENTH - 1));
    assign done      = tenth_end && (tenth_q <= 8'h01);

    // Newest request wins, so an opposite one cancels the old pulse
    always_comb
    begin
        state_d = state_q;
        if (take_up)
            state_d = ST_UP;
        else if (take_down)
            state_d = ST_DOWN;
        else if (state_q != ST_IDLE && done)
            state_d = ST_IDLE;
        else if (!allow)
            state_d = ST_IDLE;
    end

    // Length comes from the setting, not from how long the input is held
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            tick_q  <= 24'h000000;
            tenth_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            if (start)
            begin
                tick_q  <= 24'h000000;
                tenth_q <= dur_tenths;
            end
            else if (state_q != ST_IDLE)
            begin
                tick_q <= tenth_end ? 24'h000000 : tick_q + 24'h000001;
                if (tenth_end)
                    tenth_q <= tenth_q - 8'h01;
            end
        end
    end

    assign up_on   = (state_q == ST_UP);
    assign down_on = (state_q == ST_DOWN);

    AST_NO_BOTH: assert property (@(posedge clk) disable iff (sys_rst)
        !(up_on && down_on)) else $error("both step outputs on");
endmodule

// file: regctl_top.sv
// Governor and voltage regulator output selection with manual steps
// Function
// - Manual steps only in manual/semi-auto mode
// - Step length is a setting, not hold time
// - Step pulse overrides the closed-loop regulator
// - Regulator resumes when the step expires
// - Governor step length 0.1-10 s, default 5
// - Regulator step length 0.1-10 s, default 5
// - Governor drive type selectable, engine default
// - Regulator drive type selectable, analogue default
// - Governor analogue offset 0-100 %, default 50
// - Separate increase/decrease relays per regulator
// - External set point replaces the internal one
// - External modes: freq/power; volt/var/pf
//
// Design decisions made here: the address-and-strobe port and the address map.
`include "regctl_consts.svh"
module regctl_top
#(
    parameter int TICKS_PER_TENTH = `CLK_HZ / 1000 * `STEP_UNIT_MS
)
(
    input  wire logic                 clk,          // 10 MHz clock
    input  wire logic                 sys_rst,      // Async reset, high
    input  wire logic [3:0]           addr,         // Register index
    input  wire logic [15:0]          wdata,        // Write data
    input  wire logic                 wr,           // Write strobe
    input  wire logic                 rd,           // Read strobe
    output logic [15:0]               rdata,        // Read data, next cycle
    input  wire logic                 manual_mode,  // Manual or semi-auto
    input  wire regctl_pkg::step_req_t gov_pin,     // Governor step inputs
    input  wire regctl_pkg::step_req_t avr_pin,     // Regulator step inputs
    input  wire regctl_pkg::step_req_t gov_operator_panel_button, // Buttons
    input  wire regctl_pkg::step_req_t voltage_regulator_button,  // Buttons
    input  wire logic [15:0]          gov_loop,     // Closed-loop gov value
    input  wire logic [15:0]          avr_loop,     // Closed-loop avr value
    input  wire logic                 gov_loop_inc, // Loop relay increase
    input  wire logic                 gov_loop_dec, // Loop relay decrease
    input  wire logic                 avr_loop_inc, // Loop relay increase
    input  wire logic                 avr_loop_dec, // Loop relay decrease
    input  wire logic [15:0]          gov_multi_in, // External gov set point
    input  wire logic [15:0]          avr_multi_in, // External avr set point
    input  wire logic [15:0]          gov_int_sp,   // Internal gov set point
    input  wire logic [15:0]          avr_int_sp,   // Internal avr set point
    output regctl_pkg::reg_drive_t    gov_out,      // Governor drive
    output regctl_pkg::reg_drive_t    voltage_regulator_out, // Regulator
    output logic [15:0]               gov_setpoint, // Set point in use
    output logic [15:0]               avr_setpoint, // Set point in use
    output logic                      loop_hold     // Loop suspended, gov|avr
);
    import regctl_pkg::*;

    localparam logic [15:0] STEP_FULL = 16'hFFFF;   // Step drive level

    // Pin and button inputs come from other domains: two flops each
    logic [8:0]  sync1_q;                           // First stage only
    logic [8:0]  sync2_q;                           // Safe stage
    logic [8:0]  sync3_q;                           // For edge detect
    logic        mode_s;                            // Synced mode
    logic [3:0]  rise;                              // Request edges
    logic        gov_up_req;                        // Any gov up request
    logic        gov_dn_req;                        // Any gov down request
    logic        avr_up_req;                        // Any avr up request
    logic        avr_dn_req;                        // Any avr down request

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            sync3_q <= 9'h000;
        end
        else
        begin
            // Order: mode, gov pin, avr pin, gov button, avr button
            sync1_q <= {manual_mode, gov_pin, avr_pin,
                        gov_operator_panel_button,
                        voltage_regulator_button};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    function automatic logic edge_of(input logic now, input logic old);
        edge_of = now && !old;
    endfunction

    assign mode_s = sync2_q[8];
    // Pin and button of the same direction share one request line
    assign gov_up_req = edge_of(sync2_q[7], sync3_q[7]) ||
                        edge_of(sync2_q[3], sync3_q[3]);
    assign gov_dn_req = edge_of(sync2_q[6], sync3_q[6]) ||
                        edge_of(sync2_q[2], sync3_q[2]);
    assign avr_up_req = edge_of(sync2_q[5], sync3_q[5]) ||
                        edge_of(sync2_q[1], sync3_q[1]);
    assign avr_dn_req = edge_of(sync2_q[4], sync3_q[4]) ||
                        edge_of(sync2_q[0], sync3_q[0]);
    assign rise = {gov_up_req, gov_dn_req, avr_up_req, avr_dn_req};

    // Configuration registers
    logic [15:0] gov_ctrl_q;                        // Drive, ext enable, mode
    logic [15:0] avr_ctrl_q;                        // Drive, ext enable, mode
    logic [7:0]  gov_step_q;                        // Gov step in 0.1 s
    logic [7:0]  avr_step_q;                        // Avr step in 0.1 s
    logic [7:0]  gov_ofs_q;                         // Gov offset percent
    logic [15:0] rdata_q;                           // Read data register
    logic [15:0] rdata_d;                           // Read mux
    logic [7:0]  wclip_step;                        // Clamped step write
    logic [7:0]  wclip_ofs;                         // Clamped offset write

    // Out-of-range writes are clamped so the timer never sees zero
    function automatic logic [7:0] clamp(input logic [7:0] v,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    assign wclip_step = clamp(wdata[7:0], `STEP_MIN_TENTHS,
                              `STEP_MAX_TENTHS);
    assign wclip_ofs  = clamp(wdata[7:0], 8'h00, `OFFSET_MAX_PCT);

    // Writes land on the edge that samples the strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gov_ctrl_q <= {14'h0000, DRIVE_ENGINE};
            avr_ctrl_q <= {14'h0000, DRIVE_ANALOG};
            gov_step_q <= `STEP_DEF_TENTHS;
            avr_step_q <= `STEP_DEF_TENTHS;
            gov_ofs_q  <= `OFFSET_DEF_PCT;
        end
        else if (wr)
        begin
            case (addr)
                `REG_GOV_CTRL:   gov_ctrl_q <= {11'h000, wdata[4:0]};
                `REG_AVR_CTRL:   avr_ctrl_q <= {11'h000, wdata[4:0]};
                `REG_GOV_STEP:   gov_step_q <= wclip_step;
                `REG_AVR_STEP:   avr_step_q <= wclip_step;
                `REG_GOV_OFFSET: gov_ofs_q  <= wclip_ofs;
                default:         ;
            endcase
        end
    end

    // Step channels, one per regulator
    logic gov_up;                                   // Gov increase step
    logic gov_dn;                                   // Gov decrease step
    logic avr_up;                                   // Avr increase step
    logic avr_dn;                                   // Avr decrease step

    // Both channels share the synced mode, so they stop together
    step_pulse #(.TICKS_PER_TENTH(TICKS_PER_TENTH)) u_gov_step
    (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .allow      (mode_s),
        .up_req     (rise[3]),
        .down_req   (rise[2]),
        .dur_tenths (gov_step_q),
        .up_on      (gov_up),
        .down_on    (gov_dn)
    );

    step_pulse #(.TICKS_PER_TENTH(TICKS_PER_TENTH)) u_avr_step
    (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .allow      (mode_s),
        .up_req     (rise[1]),
        .down_req   (rise[0]),
        .dur_tenths (avr_step_q),
        .up_on      (avr_up),
        .down_on    (avr_dn)
    );

    // Output composition: the step overrides the loop while it runs
    function automatic reg_drive_t compose(input logic [1:0]  drive,
                                           input logic        s_up,
                                           input logic        s_dn,
                                           input logic [15:0] loop_v,
                                           input logic        l_inc,
                                           input logic        l_dec,
                                           input logic [15:0] ofs);
        reg_drive_t  r;
        logic [15:0] v;
        logic [16:0] sum;
        logic [15:0] e;                 // Engine value, no offset
        r   = '0;
        sum = {1'b0, loop_v} + {1'b0, ofs};
        v   = sum[16] ? STEP_FULL : sum[15:0];
        // The offset trims the analogue output only
        e   = loop_v;
        if (s_up)
        begin
            v = STEP_FULL;
            e = STEP_FULL;
        end
        else if (s_dn)
        begin
            v = 16'h0000;
            e = 16'h0000;
        end
        case (drive)
            DRIVE_RELAY:
            begin
                r.inc_relay = s_up || (!s_dn && l_inc && !l_dec);
                r.dec_relay = s_dn || (!s_up && l_dec && !l_inc);
            end
            DRIVE_ANALOG: r.analog = v;
            DRIVE_ENGINE: r.engine = e;
            default:      ;
        endcase
        compose = r;
    endfunction

    // Drive registers; the outputs come straight from these
    logic [15:0] gov_ofs_scaled;                    // Offset to full scale
    logic [23:0] ofs_prod;                          // Percent times 655
    reg_drive_t  gov_d;                             // Next gov drive
    reg_drive_t  avr_d;                             // Next avr drive
    reg_drive_t  gov_q;                             // Gov drive register
    reg_drive_t  avr_q;                             // Avr drive register
    logic [15:0] gov_sp_q;                          // Gov set point register
    logic [15:0] avr_sp_q;                          // Avr set point register
    logic        hold_q;                            // Any step active

    // Full percent lands just under full scale, a small loss of span
    assign ofs_prod       = {16'h0000, gov_ofs_q} * `OFS_SCALE;
    assign gov_ofs_scaled = ofs_prod[15:0];
    assign gov_d = compose(gov_ctrl_q[1:0], gov_up, gov_dn, gov_loop,
                           gov_loop_inc, gov_loop_dec, gov_ofs_scaled);
    assign avr_d = compose(avr_ctrl_q[1:0], avr_up, avr_dn, avr_loop,
                           avr_loop_inc, avr_loop_dec, 16'h0000);

    // External control picks the multi-input; mode only tags its meaning
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gov_q    <= '0;
            avr_q    <= '0;
            gov_sp_q <= 16'h0000;
            avr_sp_q <= 16'h0000;
            hold_q   <= 1'b0;
            rdata_q  <= 16'h0000;
        end
        else
        begin
            gov_q    <= gov_d;
            avr_q    <= avr_d;
            gov_sp_q <= gov_ctrl_q[`EXT_EN_BIT] ? gov_multi_in
                                                : gov_int_sp;
            avr_sp_q <= avr_ctrl_q[`EXT_EN_BIT] ? avr_multi_in
                                                : avr_int_sp;
            hold_q   <= gov_up | gov_dn | avr_up | avr_dn;
            rdata_q  <= rdata_d;
        end
    end

    // Read mux; unmapped indexes and idle cycles read zero
    always_comb
    begin
        rdata_d = 16'h0000;
        if (rd)
        begin
            case (addr)
                `REG_GOV_CTRL:   rdata_d = gov_ctrl_q;
                `REG_AVR_CTRL:   rdata_d = avr_ctrl_q;
                `REG_GOV_STEP:   rdata_d = {8'h00, gov_step_q};
                `REG_AVR_STEP:   rdata_d = {8'h00, avr_step_q};
                `REG_GOV_OFFSET: rdata_d = {8'h00, gov_ofs_q};
                `REG_GOV_EXT_SP: rdata_d = gov_sp_q;
                `REG_AVR_EXT_SP: rdata_d = avr_sp_q;
                `REG_STATUS:     rdata_d = {11'h000, mode_s, gov_up,
                                            gov_dn, avr_up, avr_dn};
                default:         rdata_d = 16'h0000;
            endcase
        end
    end

    // No logic after the registers on any output
    assign rdata                 = rdata_q;
    assign gov_out               = gov_q;
    assign voltage_regulator_out = avr_q;
    assign gov_setpoint          = gov_sp_q;
    assign avr_setpoint          = avr_sp_q;
    assign loop_hold             = hold_q;

    // Governor channel checks, plus the avr step range and avr routing checks
    AST_RELAY_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
        !(gov_q.inc_relay && gov_q.dec_relay))
        else $error("gov relays both on");
    AST_STEP_WINS: assert property (@(posedge clk) disable iff (sys_rst)
        (gov_up && gov_ctrl_q[1:0] == DRIVE_ENGINE) |=>
        (gov_q.engine == STEP_FULL))
        else $error("step did not override loop");
    AST_STEP_MIN: assert property (@(posedge clk) disable iff (sys_rst)
        gov_step_q >= `STEP_MIN_TENTHS && gov_step_q <= `STEP_MAX_TENTHS)
        else $error("gov step out of range");
    AST_AVR_STEP_RANGE: assert property (@(posedge clk)
        disable iff (sys_rst)
        avr_step_q >= `STEP_MIN_TENTHS && avr_step_q <= `STEP_MAX_TENTHS)
        else $error("avr step out of range");
    AST_OFS_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
        gov_ofs_q <= `OFFSET_MAX_PCT)
        else $error("offset out of range");
    AST_EXT_SP: assert property (@(posedge clk) disable iff (sys_rst)
        gov_ctrl_q[`EXT_EN_BIT] |=> (gov_sp_q == $past(gov_multi_in)))
        else $error("external set point not used");
    AST_NO_STEP_AUTO: assert property (@(posedge clk) disable iff (sys_rst)
        (!mode_s && !gov_up) |=> !gov_up)
        else $error("step started outside manual mode");
    AST_RELAY_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
        (gov_ctrl_q[1:0] != DRIVE_RELAY) |=> !gov_q.inc_relay)
        else $error("relay driven in non-relay mode");
    AST_AVR_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
        (avr_ctrl_q[1:0] == DRIVE_ANALOG) |-> (avr_d.engine == 16'h0000))
        else $error("avr routed to wrong output");

    // Regulator channel: relay exclusion, step override and external set point checks
    AST_AVR_RELAY_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
        !(avr_q.inc_relay && avr_q.dec_relay))
        else $error("avr relays both on");
    AST_AVR_STEP_WINS: assert property (@(posedge clk)
        disable iff (sys_rst)
        (avr_dn && avr_ctrl_q[1:0] == DRIVE_RELAY) |=>
        (avr_q.dec_relay && !avr_q.inc_relay))
        else $error("avr step did not override loop");
    AST_AVR_EXT_SP: assert property (@(posedge clk) disable iff (sys_rst)
        avr_ctrl_q[`EXT_EN_BIT] |=> (avr_sp_q == $past(avr_multi_in)))
        else $error("avr external set point not used");

    // A step has stages: accepted edge, running step, held loop
    sequence seq_gov_up_taken;
        mode_s && rise[3] && !rise[2];
    endsequence
    sequence seq_gov_up_running;
        gov_up ##1 hold_q;
    endsequence
    AST_STEP_START: assert property (@(posedge clk) disable iff (sys_rst)
        seq_gov_up_taken |=> seq_gov_up_running)
        else $error("accepted request gave no step");
endmodule

// file: plant_model.sv
// Far-side model of a governor or voltage regulator driven by relays
module plant_model
(
    input  wire logic                   clk,      // System clock
    input  wire logic                   clr,      // Clears the tallies
    input  wire regctl_pkg::reg_drive_t drv,      // Drive from controller
    output logic [15:0]                 inc_cnt,  // Cycles told to raise
    output logic [15:0]                 dec_cnt,  // Cycles told to lower
    output logic [15:0]                 both_cnt  // Cycles told both ways
);
    timeunit 1ns;
    timeprecision 1ns;
    import regctl_pkg::*;
    // A real actuator integrates relay on-time; only the tally matters here
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            inc_cnt  <= 16'h0000;
            dec_cnt  <= 16'h0000;
            both_cnt <= 16'h0000;
        end
        else
        begin
            inc_cnt  <= inc_cnt + 16'(drv.inc_relay);
            dec_cnt  <= dec_cnt + 16'(drv.dec_relay);
            both_cnt <= both_cnt + 16'(drv.inc_relay & drv.dec_relay);
        end
    end
endmodule

// file: regctl_top_tb.sv
// Self-checking bench for the regulator output control block
module regctl_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import regctl_pkg::*;
    logic        clk, sys_rst, wr, rd, manual_mode, clr;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, gov_loop, avr_loop, gmi, ami, gsp_i, asp_i;
    logic [15:0] gsp, asp, r, ai, ad, ab, gi, gd, gb;
    logic        gli, gld, ali, ald, loop_hold;
    step_req_t   gov_pin, avr_pin, gbtn, abtn;
    reg_drive_t  gov_out, avr_out;
    int          n_mismatch, checks, cyc, hold_n, ff_n;
    integer      seed;
    logic [7:0]  ofs;
    regctl_top #(.TICKS_PER_TENTH(10)) uut (.clk(clk), .sys_rst(sys_rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .manual_mode(manual_mode), .gov_pin(gov_pin), .avr_pin(avr_pin),
        .gov_operator_panel_button(gbtn), .voltage_regulator_button(abtn),
        .gov_loop(gov_loop), .avr_loop(avr_loop), .gov_loop_inc(gli),
        .gov_loop_dec(gld), .avr_loop_inc(ali), .avr_loop_dec(ald),
        .gov_multi_in(gmi), .avr_multi_in(ami), .gov_int_sp(gsp_i),
        .avr_int_sp(asp_i), .gov_out(gov_out),
        .voltage_regulator_out(avr_out), .gov_setpoint(gsp),
        .avr_setpoint(asp), .loop_hold(loop_hold));
    plant_model gov_plant (.clk(clk), .clr(clr), .drv(gov_out),
        .inc_cnt(gi), .dec_cnt(gd), .both_cnt(gb));
    plant_model avr_plant (.clk(clk), .clr(clr), .drv(avr_out),
        .inc_cnt(ai), .dec_cnt(ad), .both_cnt(ab));
    // Clock of 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard and step monitors; the run needs far fewer cycles
    always @(posedge clk)
    begin
        cyc++;
        if (loop_hold === 1'b1) hold_n++;
        if (gov_out.analog === 16'hFFFF) ff_n++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checks++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Expected analogue: loop plus offset steps, saturated at full scale
    function automatic logic [15:0] ana(input logic [15:0] l,
                                        input logic [7:0] o);
        logic [17:0] s;
        s = 18'(l) + 18'(o) * 18'h0028F;
        return (s > 18'h0FFFF) ? 16'hFFFF : s[15:0];
    endfunction
    task automatic wrap_up();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        seed = 28940;
        {wr, rd, manual_mode, gli, gld, ali, ald, addr, wdata} = '0;
        {gov_loop, avr_loop, gmi, ami, gov_pin, avr_pin, gbtn, abtn} = '0;
        gsp_i = 16'h1111;
        asp_i = 16'h2222;
        sys_rst = 1'b1;
        clr = 1'b1;
        tick(8);
        sys_rst <= 1'b0;
        clr <= 1'b0;
        rreg(4'h0, r); chk(r & 16'h0003, 16'(DRIVE_ENGINE));
        rreg(4'h1, r); chk(r & 16'h0003, 16'(DRIVE_ANALOG));
        rreg(4'h2, r); chk(r, 16'h0032);
        rreg(4'h3, r); chk(r, 16'h0032);
        rreg(4'h4, r); chk(r, 16'h0032);
        rreg(4'h8, r); chk(r, 16'h0000);
        // Step lengths saturate at both ends of the range
        for (int a = 2; a < 4; a++)
        begin
            wreg(4'(a), 16'h0000);
            rreg(4'(a), r); chk(r, 16'h0001);
            wreg(4'(a), 16'h00C8);
            rreg(4'(a), r); chk(r, 16'h0064);
        end
        // Each drive type routes to its own field only
        for (int d = 0; d < 3; d++)
        begin
            ofs = 8'({$random(seed)} % 101);
            wreg(4'h4, 16'(ofs));
            wreg(4'h0, 16'(d));
            wreg(4'h1, 16'(d));
            gov_loop <= 16'($random(seed));
            avr_loop <= 16'($random(seed));
            {gli, gld, ali, ald} <= 4'h9;
            tick(3);
            #1;
            chk(gov_out.engine, d == 2 ? gov_loop : 16'h0000);
            chk(gov_out.analog, d == 1 ? ana(gov_loop, ofs) : 16'h0000);
            chk(avr_out.analog, d == 1 ? avr_loop : 16'h0000);
            chk(avr_out.engine, d == 2 ? avr_loop : 16'h0000);
            chk(16'(gov_out.inc_relay), d == 0);
            chk(16'(avr_out.dec_relay), d == 0);
        end
        // External set points in every mode, then back to internal
        for (int k = 0; k < 3; k++)
        begin
            wreg(4'h0, 16'h0005 | 16'((k % 2) << 3));
            wreg(4'h1, 16'h0005 | 16'(k << 3));
            gmi <= 16'($random(seed));
            ami <= 16'($random(seed));
            tick(3);
            #1;
            chk(gsp, gmi);
            chk(asp, ami);
            rreg(4'h5, r); chk(r, gmi);
            rreg(4'h1, r); chk(r, 16'h0005 | 16'(k << 3));
        end
        wreg(4'h0, 16'h0001);
        wreg(4'h1, 16'h0000);
        tick(3);
        #1;
        chk(gsp, gsp_i);
        chk(asp, asp_i);
        // Step requests outside manual mode do nothing
        wreg(4'h2, 16'h0002);
        wreg(4'h3, 16'h0002);
        wreg(4'h4, 16'h0000);
        gov_loop <= 16'h1234;
        {gli, gld, ali, ald} <= 4'h0;
        gov_pin.up <= 1'b1;
        tick(40);
        gov_pin.up <= 1'b0;
        #1 chk(16'(hold_n), 16'h0000);
        // A request held longer than the step still gives one step
        tick(4);
        manual_mode <= 1'b1;
        tick(4);
        #1 {hold_n, ff_n} = '0;
        tick(1);
        gov_pin.up <= 1'b1;
        tick(40);
        gov_pin.up <= 1'b0;
        tick(20);
        #1;
        chk(16'(hold_n), 16'h0014);
        chk(16'(ff_n), 16'h0014);
        chk(gov_out.analog, 16'h1234);
        // Opposite button mid-step cancels, relays never overlap
        tick(1);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        avr_pin.up <= 1'b1;
        tick(8);
        abtn.down <= 1'b1;
        tick(40);
        {avr_pin, abtn} <= '0;
        #1;
        chk(16'(ai != 0 && ai < 16'h0014), 16'h0001);
        chk(ad, 16'h0014);
        chk(ab, 16'h0000);
        // Engine drive: button step up, then an opposite pin step
        wreg(4'h0, 16'h0002);
        gbtn.up <= 1'b1;
        tick(5);
        #1 chk(gov_out.engine, 16'hFFFF);
        tick(1);
        gov_pin.down <= 1'b1;
        tick(5);
        #1 chk(gov_out.engine, 16'h0000);
        rreg(4'h7, r); chk(r, 16'h0014);
        tick(25);
        #1 chk(gov_out.engine, 16'h1234);
        wrap_up();
    end
endmodule
